// >>> core/srp_defines.vh
// Operation
// - every mode register is readable and writable through the port
// - a select bit chooses three-wire or four-wire; same clock and enable
// - three-wire: the one data pin carries both input and output data
// - first byte is instruction; bit 7 high means read, low means write
// - instruction bits 6:5 give data bytes: 00 one up to 11 four
// - instruction bits 4:0 give the start register address
// - all bytes shift most significant bit first
// - incoming data sampled on each rising serial clock edge
// - read: data pin is input for instruction, three-wire drives data, out pin floats
// - four-wire read: data driven on the dedicated output pin
// - after read, out pin low from last falling edge until enable rises; driven so in four-wire only, three-wire leaves it floating
`ifndef SRP_DEFINES_VH
`define SRP_DEFINES_VH
`define SRP_INST_RW      7
`define SRP_INST_CNT_HI  6
`define SRP_INST_CNT_LO  5
`define SRP_INST_ADR_HI  4
`define SRP_BIT_LAST     3'h7
`define SRP_BIT_FIRST    3'h0
`define SRP_REG_RESET    8'h00
`define SRP_ADR_STEP     5'h01
`endif

// >>> core/srp_serial_register_port.v
`timescale 1ns/100ps
`include "srp_defines.vh"

module srp_serial_register_port #(
    parameter NREG = 32
) (
    input  wire        i_mclk,
    input  wire        i_rst_n,
    input  wire        i_four_wire_select,
    input  wire        i_sclk,
    input  wire        i_serial_enable_n,
    input  wire        i_sdio,
    input  wire        i_serial_out_pin,
    output reg         o_sdio,
    output reg         o_sdio_oe,
    output reg         o_serial_out_pin,
    output reg         o_serial_out_pin_oe,
    output reg  [7:0]  o_reg_wdata,
    output reg  [4:0]  o_reg_waddr,
    output reg         o_reg_we,
    output reg  [8*NREG-1:0] o_reg_file
);

    // two-stage synchronisers; stage one is read by stage two only
    reg  [2:0] sclk_s;
    reg  [1:0] en_s;
    reg  [1:0] din_s;
    reg  [7:0] mem [0:NREG-1];
    reg  [7:0] shreg;
    reg  [7:0] txreg;
    reg  [2:0] bitcnt;
    reg        inst_done;
    reg        rd;
    reg  [1:0] left;
    reg  [4:0] addr;
    reg        rd_end;
    wire       rise = sclk_s[1] & ~sclk_s[2];
    wire       fall = ~sclk_s[1] & sclk_s[2];
    wire       act  = ~en_s[1];
    wire [7:0] nxt  = {shreg[6:0], din_s[1]};
    integer    k;

    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sclk_s <= 3'h0;
            en_s   <= 2'h3;
            din_s  <= 2'h0;
        end else begin
            sclk_s <= {sclk_s[1], sclk_s[0], i_sclk};
            en_s   <= {en_s[0], i_serial_enable_n};
            // three-wire in, or dedicated pin unused: data always arrives on sdio
            din_s  <= {din_s[0], i_sdio};
        end
    end

    // frame engine; enable high aborts and rearms
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shreg     <= 8'h00;
            txreg     <= 8'h00;
            bitcnt    <= `SRP_BIT_FIRST;
            inst_done <= 1'b0;
            rd        <= 1'b0;
            left      <= 2'h0;
            addr      <= 5'h00;
            rd_end    <= 1'b0;
            o_reg_we  <= 1'b0;
            o_reg_wdata <= 8'h00;
            o_reg_waddr <= 5'h00;
            for (k = 0; k < NREG; k = k + 1)
                mem[k] <= `SRP_REG_RESET;
        end else begin
            o_reg_we <= 1'b0;
            if (!act) begin
                bitcnt    <= `SRP_BIT_FIRST;
                inst_done <= 1'b0;
                rd_end    <= 1'b0;
                rd        <= 1'b0;
            end else if (rise) begin
                shreg  <= nxt;
                bitcnt <= bitcnt + 3'h1;
                if (bitcnt == `SRP_BIT_LAST) begin
                    if (!inst_done) begin
                        inst_done <= 1'b1;
                        rd   <= nxt[`SRP_INST_RW];
                        left <= nxt[`SRP_INST_CNT_HI:`SRP_INST_CNT_LO];
                        addr <= nxt[`SRP_INST_ADR_HI:0];
                        txreg <= mem[nxt[`SRP_INST_ADR_HI:0]];
                    end else if (!rd_end) begin
                        if (!rd) begin
                            mem[addr]   <= nxt;
                            o_reg_we    <= 1'b1;
                            o_reg_wdata <= nxt;
                            o_reg_waddr <= addr;
                        end
                        addr  <= addr + `SRP_ADR_STEP;
                        txreg <= mem[addr + `SRP_ADR_STEP];
                        left  <= left - 2'h1;
                        // extra bytes beyond the count are ignored until enable rises
                        if (left == 2'h0)
                            rd_end <= 1'b1;
                    end
                end
            end
        end
    end

    // read driver; launches on falling edges
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sdio              <= 1'b0;
            o_sdio_oe           <= 1'b0;
            o_serial_out_pin    <= 1'b0;
            o_serial_out_pin_oe <= 1'b0;
        end else if (!act) begin
            o_sdio_oe           <= 1'b0;
            o_serial_out_pin_oe <= 1'b0;
            o_serial_out_pin    <= 1'b0;
        end else if (fall && inst_done && rd) begin
            if (rd_end) begin
                // last falling edge: quiet low on out pin in four-wire mode
                o_sdio_oe           <= 1'b0;
                o_serial_out_pin    <= 1'b0;
                o_serial_out_pin_oe <= i_four_wire_select;
            end else if (i_four_wire_select) begin
                o_serial_out_pin    <= txreg[`SRP_BIT_LAST - bitcnt];
                o_serial_out_pin_oe <= 1'b1;
                o_sdio_oe           <= 1'b0;
            end else begin
                o_sdio              <= txreg[`SRP_BIT_LAST - bitcnt];
                o_sdio_oe           <= 1'b1;
                o_serial_out_pin_oe <= 1'b0;
            end
        end
    end

    // flat view of the register bank for device logic
    genvar g;
    generate
        for (g = 0; g < NREG; g = g + 1) begin : g_flat
            always @(posedge i_mclk or negedge i_rst_n) begin
                if (!i_rst_n)
                    o_reg_file[8*g+7:8*g] <= `SRP_REG_RESET;
                else
                    o_reg_file[8*g+7:8*g] <= mem[g];
            end
        end
    endgenerate

endmodule // srp_serial_register_port

// >>> sim/srp_checker.sv
`timescale 1ns/100ps
module srp_checker #(parameter NREG = 32) (
    input logic i_mclk, i_rst_n, i_four_wire_select, i_sclk, i_serial_enable_n, o_reg_we,
    input logic o_sdio_oe, o_serial_out_pin, o_serial_out_pin_oe,
    input logic [7:0] o_reg_wdata,
    input logic [4:0] o_reg_waddr,
    input logic [8*NREG-1:0] o_reg_file
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    logic [7:0] wd;
    logic [4:0] wa;
    logic seen; // a write already landed in this frame
    // remember last write; frame gap clears the step check
    always @(posedge i_mclk or negedge i_rst_n)
        if (!i_rst_n) {wd, wa, seen} <= 14'h0000;
        else if (o_reg_we) {wd, wa, seen} <= {o_reg_wdata, o_reg_waddr, 1'b1};
        else if (i_serial_enable_n) seen <= 1'b0;
    property p_we; o_reg_we |=> !o_reg_we; endproperty
    a_we: assert property (p_we) else $error("we too long");
    property p_file; o_reg_we |-> ##[1:4] o_reg_file[8*wa +: 8] == wd; endproperty
    a_file: assert property (p_file) else $error("file miss");
    property p_step; o_reg_we && seen |-> o_reg_waddr == wa + 5'h01; endproperty
    a_step: assert property (p_step) else $error("addr step");
    property p_oe3; o_sdio_oe |-> !i_four_wire_select; endproperty
    a_oe3: assert property (p_oe3) else $error("sdio oe");
    property p_oe4; o_serial_out_pin_oe |-> i_four_wire_select; endproperty
    a_oe4: assert property (p_oe4) else $error("out oe");
    property p_launch; o_serial_out_pin_oe && $changed(o_serial_out_pin) |-> !i_sclk; endproperty
    a_launch: assert property (p_launch) else $error("launch edge");
    property p_end; $fell(o_serial_out_pin_oe) |-> i_serial_enable_n && !$past(o_serial_out_pin);
    endproperty
    a_end: assert property (p_end) else $error("out end");
    property p_idle; i_serial_enable_n [*8] |-> !o_sdio_oe && !o_serial_out_pin_oe; endproperty
    a_idle: assert property (p_idle) else $error("idle drive");
    c_step: cover property (o_reg_we && seen);
    c_end: cover property ($fell(o_serial_out_pin_oe));
    c_three: cover property ($rose(o_sdio_oe));
endmodule // srp_checker
bind srp_serial_register_port srp_checker #(.NREG(NREG)) srp_checker_i (.*);

// >>> sim/srp_host.sv
`timescale 1ns/100ps
module srp_host (
    output logic      o_sclk,
    output logic      o_en_n,
    output logic      o_sdio,
    input  wire logic i_sdio,
    input  wire logic i_sop,
    input  wire logic i_sel
);
    initial begin
        {o_sclk, o_en_n, o_sdio} = 3'h2;
    end
    // one frame, 64 ns link period; read data comes back right-aligned
    task xfer(input logic [7:0] inst, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 8 * (inst[6:5] + 1);
        rd = 0;
        o_en_n = 0;
        #40;
        for (int i = 0; i < 8 + n; i++) begin
            if (i < 8) o_sdio = inst[7-i];
            else if (inst[7]) o_sdio = ~o_sdio; // released line toggles
            else o_sdio = wd[n+7-i];
            #32 o_sclk = 1;
            if (i >= 8) rd = {rd[30:0], i_sel ? i_sop : i_sdio};
            #32 o_sclk = 0;
        end
        #32;
    endtask
    task stop;
        o_en_n = 1;
        #200;
    endtask
endmodule // srp_host

// >>> sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic i_mclk = 0, i_rst_n = 0, i_four_wire_select = 0;
    logic i_sclk, i_serial_enable_n, h_sdio;
    wire i_sdio, i_serial_out_pin, o_sdio, o_sdio_oe, o_serial_out_pin, o_serial_out_pin_oe;
    wire o_reg_we;
    wire [7:0] o_reg_wdata;
    wire [4:0] o_reg_waddr;
    wire [255:0] o_reg_file;
    int err_total = 0, num_checks = 0;
    logic [31:0] rd, v, mask;
    logic [4:0] a;
    always #2.5 i_mclk = ~i_mclk;
    // undriven sdio shows the host's toggling line; undriven out pin shows the inverse of its held value
    assign i_sdio = o_sdio_oe ? o_sdio : h_sdio;
    assign i_serial_out_pin = o_serial_out_pin_oe ? o_serial_out_pin : ~o_serial_out_pin;
    srp_serial_register_port srp_serial_register_port_i (.*);
    srp_host srp_host_i (.o_sclk(i_sclk), .o_en_n(i_serial_enable_n), .o_sdio(h_sdio),
        .i_sdio(i_sdio), .i_sop(i_serial_out_pin), .i_sel(i_four_wire_select));
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", s, e, g);
        end
    endtask
    task results;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #100000 err_total++;
        results;
    end
    // every count, both arrangements: write then read back
    initial begin
        repeat (16) @(posedge i_mclk);
        #0.5 i_rst_n = 1;
        #100 chk("reset", 32'h0, o_reg_file[31:0]);
        for (int m = 0; m < 2; m++) for (int c = 0; c < 4; c++) begin
            @(posedge i_mclk);
            #0.5 i_four_wire_select = m[0];
            a = 5'h02 + 5'h07 * c[4:0] + m[4:0];
            v = 32'h8d4c2b1a + a;
            mask = 32'hffffffff >> (8 * (3 - c));
            srp_host_i.xfer({1'b0, c[1:0], a}, v & mask, rd);
            srp_host_i.stop;
            chk("first", v[8*c +: 8], o_reg_file[8*a +: 8]);
            chk("last", v[7:0], o_reg_file[8*(a+c) +: 8]);
            srp_host_i.xfer({1'b1, c[1:0], a}, 32'h0, rd);
            chk("end", {1'b0, m[0]}, {o_serial_out_pin, o_serial_out_pin_oe});
            srp_host_i.stop;
            chk("read", v & mask, rd);
            chk("free", 2'b00, {o_sdio_oe, o_serial_out_pin_oe});
        end
        results;
    end
endmodule // tb_top
